// file: logic/iwd_pkg.sv
package iwd_pkg;

  // word and field geometry
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned CLS_HI = 13;
  localparam int unsigned CLS_LO = 12;
  localparam int unsigned OPC_HI = 11;
  localparam int unsigned OPC_LO = 8;
  localparam int unsigned FILE_LSB = 0;
  localparam int unsigned FILE_W = 7;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned BIT_LSB = 7;
  localparam int unsigned BIT_W = 3;
  localparam int unsigned BIT_TEST_BIT = 11;
  localparam int unsigned BIT_SENSE_BIT = 10;
  localparam int unsigned JUMP_SEL_BIT = 11;
  localparam int unsigned LIT8_W = 8;
  localparam int unsigned LIT11_W = 11;
  localparam int unsigned LIT5_W = 5;
  localparam int unsigned LIT7_W = 7;
  localparam int unsigned LIT9_W = 9;
  localparam int unsigned LIT6_W = 6;
  localparam int unsigned PTR_OFS_BIT = 6;
  localparam int unsigned PTR_UPD_BIT = 2;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned MODE_W = 2;
  localparam int unsigned PAGE_SEL_BIT = 7;

  // file address space and the two indirect access ports inside it
  localparam logic [6:0] FILE_MIN = 7'h00;
  localparam logic [6:0] FILE_MAX = 7'h7F;
  localparam logic [6:0] PORT0_ADDR = 7'h00;
  localparam logic [6:0] PORT1_ADDR = 7'h01;

  // control words inside the 00_0000_0xxx_xxxx group
  localparam logic [6:0] CTL_RET = 7'h08;
  localparam logic [6:0] CTL_INT_EXIT = 7'h09;
  localparam logic [6:0] CTL_ACC_CALL = 7'h0A;
  localparam logic [6:0] CTL_ACC_REL = 7'h0B;
  localparam logic [2:0] CTL_PTR_UPD = 3'h1;
  localparam logic [1:0] CTL_BANK = 2'h1;

  // 4-bit opcodes, and the 3-bit relative-branch prefix, that matter to the decoder
  localparam logic [3:0] OPC_CTL = 4'h0;
  localparam logic [3:0] OPC_DEC_SKIP = 4'hB;
  localparam logic [3:0] OPC_INC_SKIP = 4'hF;
  localparam logic [3:0] OPC_RET_LIT = 4'h4;
  localparam logic [3:0] OPC_PAGE_OFS = 4'h1;
  localparam logic [3:0] OPC_PTR_IDX = 4'hF;
  localparam logic [2:0] OPC_REL = 3'h1;
  localparam logic [3:0] OPC_HI_BYTE0 = 4'h5;
  localparam logic [3:0] OPC_HI_BYTE1 = 4'h6;
  localparam logic [3:0] OPC_HI_BYTE2 = 4'h7;
  localparam logic [3:0] OPC_HI_BYTE3 = 4'hB;
  localparam logic [3:0] OPC_HI_BYTE4 = 4'hD;

  // instruction cycle timing: phases in oscillator clocks, cycle counts in instruction cycles
  localparam int unsigned PHASES_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_RD = 2'h1;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  typedef enum logic [1:0] {
    CLS_BYTE = 2'b00,
    CLS_BIT = 2'b01,
    CLS_LITCTL = 2'b10
  } iwd_cls_e;

  typedef enum logic [4:0] {
    OP_PLAIN = 5'b00000,
    OP_CALL = 5'b00001,
    OP_JUMP = 5'b00010,
    OP_RET = 5'b00011,
    OP_RET_LIT = 5'b00100,
    OP_INT_EXIT = 5'b00101,
    OP_ACC_CALL = 5'b00110,
    OP_REL = 5'b00111,
    OP_ACC_REL = 5'b01000,
    OP_SKIP_ONE = 5'b01001,
    OP_SKIP_ZERO = 5'b01010,
    OP_DEC_SKIP = 5'b01011,
    OP_INC_SKIP = 5'b01100,
    OP_PTR_UPD = 5'b01101,
    OP_PTR_OFS = 5'b01110,
    OP_PTR_IDX = 5'b01111,
    OP_BANK = 5'b10000,
    OP_PAGE = 5'b10001
  } iwd_op_e;

  typedef struct packed {
    iwd_cls_e cls;
    iwd_op_e op;
    logic [6:0] file_addr;
    logic dest_file;
    logic [2:0] bit_num;
    logic [7:0] lit8;
    logic [10:0] lit11;
    logic [4:0] lit5;
    logic [6:0] lit7;
    logic [8:0] lit9;
    logic [5:0] lit6;
    logic ptr_sel;
    logic [1:0] ptr_mode;
    logic file_op;
    logic wr_file;
    logic wr_acc;
    logic skip;
    logic [1:0] cycles;
  } iwd_dec_s;

  typedef struct packed {
    logic busy;
    logic first;
    logic [1:0] left;
    iwd_dec_s dec;
  } iwd_state_s;

  typedef struct packed {
    logic [1:0] cnt;
  } iwd_phase_s;

endpackage

// file: logic/iwd_phase_gen.sv
`timescale 1ns/1ps
`default_nettype none

module iwd_phase_gen
  import iwd_pkg::*;
#(
  parameter int unsigned PHASES = PHASES_PER_CYCLE
) (
  input wire logic clk,
  input wire logic rst,
  output logic [1:0] phase,
  output logic cycle_end
);

  iwd_phase_s st_q;
  iwd_phase_s st_d;

  // four oscillator clocks make one instruction cycle
  always_comb begin
    st_d = st_q;
    if (st_q.cnt == 2'(PHASES - 1)) begin
      st_d.cnt = 2'h0;
    end else begin
      st_d.cnt = st_q.cnt + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign phase = st_q.cnt;
  assign cycle_end = (st_q.cnt == 2'(PHASES - 1));

  property p_cycle_len;
    @(posedge clk) disable iff (rst)
      cycle_end |-> ##1 !cycle_end [*3] ##1 cycle_end;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("cycle is not four clocks");

endmodule

`default_nettype wire

// file: logic/iwd_decoder.sv
// What this block does
// - one 14-bit word holds opcode and operands
// - sort words into byte, bit, literal/control
// - one instruction cycle unless listed otherwise
// - calls take two instruction cycles
// - all returns take two instruction cycles
// - jumps two cycles, skips two when taken
// - indirect program-memory access adds one cycle
// - instruction cycle is four oscillator clocks
// - file operands are read, modified, stored
// - file read issued even for write-only ops
// - file address spans 0x00 to 0x7F
// - destination bit: 0 accumulator, 1 file
// - bit number picks one of eight bits
// - don't-care opcode bits are ignored; clear-accumulator low bits still set the file address that is read
// - pointer number selects pointer 0 or 1
// - mode field picks pre/post increment/decrement
// - literal field gives constant or label value
`timescale 1ns/1ps
`default_nettype none

module iwd_decoder
  import iwd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic skip_taken,
  input wire logic [1:0] ptr_in_prog,
  output logic [1:0] phase,
  output logic busy,
  output logic nop_cycle,
  output iwd_cls_e instr_class,
  output iwd_op_e instr_op,
  output logic [6:0] file_addr,
  output logic dest_file,
  output logic [2:0] bit_num,
  output logic [7:0] lit8,
  output logic [10:0] lit11,
  output logic [4:0] lit5,
  output logic [6:0] lit7,
  output logic [8:0] lit9,
  output logic [5:0] lit6,
  output logic ptr_sel,
  output logic [1:0] pointer_update_mode,
  output logic [1:0] cycles,
  output logic file_rd,
  output logic file_wr,
  output logic acc_wr
);

  iwd_state_s st_q;
  iwd_state_s st_d;
  iwd_dec_s dec;
  logic cycle_end;
  logic penalty;
  logic skip_ext;
  logic [3:0] opc;
  logic [1:0] base_cyc;

  iwd_phase_gen #(
    .PHASES(PHASES_PER_CYCLE)
  ) u_phase (
    .clk(clk),
    .rst(rst),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  assign opc = instr_word[OPC_HI:OPC_LO];

  // operand fields sit at fixed places, so extract them all and let the op pick
  always_comb begin
    dec = '0;
    dec.cls = CLS_LITCTL;
    dec.op = OP_PLAIN;
    dec.file_addr = instr_word[FILE_LSB +: FILE_W];
    dec.dest_file = instr_word[DEST_BIT];
    dec.bit_num = instr_word[BIT_LSB +: BIT_W];
    dec.lit8 = instr_word[0 +: LIT8_W];
    dec.lit11 = instr_word[0 +: LIT11_W];
    dec.lit5 = instr_word[0 +: LIT5_W];
    dec.lit7 = instr_word[0 +: LIT7_W];
    dec.lit9 = instr_word[0 +: LIT9_W];
    dec.lit6 = instr_word[0 +: LIT6_W];
    dec.ptr_sel = instr_word[PTR_OFS_BIT];
    dec.ptr_mode = instr_word[MODE_LSB +: MODE_W];
    unique case (instr_word[CLS_HI:CLS_LO])
      2'b00: begin
        if (opc == OPC_CTL && !instr_word[DEST_BIT]) begin
          // control group: exact codes, the rest runs as a plain one-cycle op
          if (instr_word[6:0] == CTL_RET) begin
            dec.op = OP_RET;
          end else if (instr_word[6:0] == CTL_INT_EXIT) begin
            dec.op = OP_INT_EXIT;
          end else if (instr_word[6:0] == CTL_ACC_CALL) begin
            dec.op = OP_ACC_CALL;
          end else if (instr_word[6:0] == CTL_ACC_REL) begin
            dec.op = OP_ACC_REL;
          end else if (instr_word[6:4] == CTL_PTR_UPD) begin
            dec.op = OP_PTR_UPD;
            dec.ptr_sel = instr_word[PTR_UPD_BIT];
          end else if (instr_word[6:5] == CTL_BANK) begin
            dec.op = OP_BANK;
          end
        end else begin
          // clear-accumulator low bits still set file_addr: that file is read, and 0x00/0x01 can add the indirect-port cycle
          dec.cls = CLS_BYTE;
          dec.file_op = 1'b1;
          dec.wr_file = instr_word[DEST_BIT];
          dec.wr_acc = !instr_word[DEST_BIT];
          if (opc == OPC_DEC_SKIP) begin
            dec.op = OP_DEC_SKIP;
          end else if (opc == OPC_INC_SKIP) begin
            dec.op = OP_INC_SKIP;
          end
        end
      end
      2'b01: begin
        dec.cls = CLS_BIT;
        dec.file_op = 1'b1;
        dec.dest_file = 1'b1;
        if (instr_word[BIT_TEST_BIT]) begin
          // bit tests only read; no write-back
          dec.op = instr_word[BIT_SENSE_BIT] ? OP_SKIP_ONE : OP_SKIP_ZERO;
        end else begin
          dec.wr_file = 1'b1;
        end
      end
      2'b10: begin
        dec.op = instr_word[JUMP_SEL_BIT] ? OP_JUMP : OP_CALL;
      end
      2'b11: begin
        if (opc == OPC_HI_BYTE0 || opc == OPC_HI_BYTE1 || opc == OPC_HI_BYTE2 ||
            opc == OPC_HI_BYTE3 || opc == OPC_HI_BYTE4) begin
          dec.cls = CLS_BYTE;
          dec.file_op = 1'b1;
          dec.wr_file = instr_word[DEST_BIT];
          dec.wr_acc = !instr_word[DEST_BIT];
        end else if (opc == OPC_RET_LIT) begin
          dec.op = OP_RET_LIT;
        end else if (opc[3:1] == OPC_REL) begin
          dec.op = OP_REL;
        end else if (opc == OPC_PAGE_OFS) begin
          dec.op = instr_word[PAGE_SEL_BIT] ? OP_PAGE : OP_PTR_OFS;
        end else if (opc == OPC_PTR_IDX) begin
          dec.op = OP_PTR_IDX;
        end
      end
    endcase
    if (dec.cls == CLS_LITCTL) begin
      dec.dest_file = 1'b0;
    end
    dec.skip = (dec.op == OP_SKIP_ONE) || (dec.op == OP_SKIP_ZERO) ||
               (dec.op == OP_DEC_SKIP) || (dec.op == OP_INC_SKIP);
  end

  // program-flow changes always take a second cycle
  always_comb begin
    unique case (dec.op)
      OP_CALL, OP_ACC_CALL: base_cyc = CYC_TWO;
      OP_RET, OP_RET_LIT, OP_INT_EXIT: base_cyc = CYC_TWO;
      OP_JUMP, OP_REL, OP_ACC_REL: base_cyc = CYC_TWO;
      default: base_cyc = CYC_ONE;
    endcase
  end

  // the indirect ports, a pointer update or an indexed move through a pointer aimed at program memory
  always_comb begin
    penalty = 1'b0;
    if (dec.file_op && dec.file_addr == PORT0_ADDR) begin
      penalty = ptr_in_prog[0];
    end else if (dec.file_op && dec.file_addr == PORT1_ADDR) begin
      penalty = ptr_in_prog[1];
    end else if (dec.op == OP_PTR_UPD || dec.op == OP_PTR_IDX) begin
      penalty = ptr_in_prog[dec.ptr_sel];
    end
  end

  // a taken skip is only known at the end of the first cycle, so it holds the count
  assign skip_ext = st_q.busy && st_q.first && st_q.dec.skip && skip_taken && cycle_end;
  assign instr_ready = cycle_end && (!st_q.busy || (st_q.left == CYC_ONE && !skip_ext));

  // sequencer: a word is taken only at an instruction-cycle boundary
  always_comb begin
    st_d = st_q;
    if (cycle_end && st_q.busy) begin
      st_d.first = 1'b0;
      if (!skip_ext) begin
        st_d.left = st_q.left - 2'h1;
      end
    end
    if (instr_ready) begin
      st_d.busy = instr_valid;
      if (instr_valid) begin
        st_d.first = 1'b1;
        st_d.dec = dec;
        st_d.dec.cycles = base_cyc + {1'b0, penalty};
        st_d.left = base_cyc + {1'b0, penalty};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // decoded fields stand registered for the whole instruction
  assign busy = st_q.busy;
  assign nop_cycle = st_q.busy && !st_q.first;
  assign instr_class = st_q.dec.cls;
  assign instr_op = st_q.dec.op;
  assign file_addr = st_q.dec.file_addr;
  assign dest_file = st_q.dec.dest_file;
  assign bit_num = st_q.dec.bit_num;
  assign lit8 = st_q.dec.lit8;
  assign lit11 = st_q.dec.lit11;
  assign lit5 = st_q.dec.lit5;
  assign lit7 = st_q.dec.lit7;
  assign lit9 = st_q.dec.lit9;
  assign lit6 = st_q.dec.lit6;
  assign ptr_sel = st_q.dec.ptr_sel;
  assign pointer_update_mode = st_q.dec.ptr_mode;
  assign cycles = st_q.dec.cycles;

  // read in phase 1 always, so clear-on-read side effects happen even for pure writes
  assign file_rd = st_q.busy && st_q.first && phase == PHASE_RD && st_q.dec.file_op;
  assign file_wr = st_q.busy && st_q.first && cycle_end && st_q.dec.wr_file;
  assign acc_wr = st_q.busy && st_q.first && cycle_end && st_q.dec.wr_acc;

  // ---- checks ----
  sequence s_one_cyc;
    !instr_ready [*3] ##1 instr_ready;
  endsequence

  sequence s_two_cyc;
    !instr_ready [*7] ##1 instr_ready;
  endsequence

  property p_one_cycle;
    @(posedge clk) disable iff (rst)
      instr_valid && instr_ready && base_cyc == CYC_ONE && !penalty && !dec.skip
      |-> ##1 s_one_cyc;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("plain op not one cycle");

  property p_call_two;
    @(posedge clk) disable iff (rst)
      instr_valid && instr_ready && !penalty && (dec.op == OP_CALL || dec.op == OP_ACC_CALL)
      |-> ##1 s_two_cyc;
  endproperty
  a_call_two: assert property (p_call_two) else $error("call not two cycles");

  property p_ret_two;
    @(posedge clk) disable iff (rst)
      instr_valid && instr_ready && !penalty &&
      (dec.op == OP_RET || dec.op == OP_RET_LIT || dec.op == OP_INT_EXIT)
      |-> ##1 s_two_cyc;
  endproperty
  a_ret_two: assert property (p_ret_two) else $error("return not two cycles");

  property p_skip_two;
    @(posedge clk) disable iff (rst)
      skip_ext && st_q.left == CYC_ONE |-> !instr_ready ##1 s_one_cyc;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("taken skip not extended");

  property p_penalty;
    @(posedge clk) disable iff (rst)
      instr_valid && instr_ready && penalty |-> ##1 st_q.left == $past(base_cyc) + 2'h1;
  endproperty
  a_penalty: assert property (p_penalty) else $error("indirect penalty missing");

  property p_rmw;
    @(posedge clk) disable iff (rst)
      file_rd && st_q.dec.wr_file |-> ##2 file_wr;
  endproperty
  a_rmw: assert property (p_rmw) else $error("write-back does not follow read");

  property p_read_always;
    @(posedge clk) disable iff (rst)
      instr_valid && instr_ready && dec.file_op |-> ##2 file_rd;
  endproperty
  a_read_always: assert property (p_read_always) else $error("file read skipped");

  property p_dest;
    @(posedge clk) disable iff (rst)
      (acc_wr |-> !dest_file) and (file_wr |-> dest_file || instr_class == CLS_BIT);
  endproperty
  a_dest: assert property (p_dest) else $error("destination bit not honoured");

  property p_fields;
    @(posedge clk) disable iff (rst)
      instr_valid && instr_ready |-> ##1 bit_num == $past(instr_word[9:7]) &&
      file_addr == $past(instr_word[6:0]) && lit8 == $past(instr_word[7:0]);
  endproperty
  a_fields: assert property (p_fields) else $error("operand field misplaced");

  property p_class;
    @(posedge clk) disable iff (rst)
      busy |-> instr_class != 2'b11 && (st_q.dec.file_op == (instr_class != CLS_LITCTL));
  endproperty
  a_class: assert property (p_class) else $error("bad instruction class");

  property p_jump_two;
    @(posedge clk) disable iff (rst)
      instr_valid && instr_ready && !penalty &&
      (dec.op == OP_JUMP || dec.op == OP_REL || dec.op == OP_ACC_REL)
      |-> ##1 s_two_cyc;
  endproperty
  a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

  // an untaken skip must not be stretched by the verdict logic
  property p_skip_miss;
    @(posedge clk) disable iff (rst)
      busy && st_q.first && st_q.dec.skip && !skip_taken && cycle_end &&
      st_q.left == CYC_ONE |-> instr_ready;
  endproperty
  a_skip_miss: assert property (p_skip_miss) else $error("untaken skip stretched");

  property p_ptr_fields;
    @(posedge clk) disable iff (rst)
      instr_valid && instr_ready |-> ##1 pointer_update_mode == $past(instr_word[1:0]) &&
      ptr_sel == (instr_op == OP_PTR_UPD ? $past(instr_word[2]) : $past(instr_word[6]));
  endproperty
  a_ptr_fields: assert property (p_ptr_fields) else $error("pointer field misplaced");

  // reset is checked on its own, so no disable clause here
  property p_reset;
    @(posedge clk) rst |=> !busy && phase == 2'h0 && !instr_ready;
  endproperty
  a_reset: assert property (p_reset) else $error("reset left state behind");

  property p_lit_wide;
    @(posedge clk) disable iff (rst)
      instr_valid && instr_ready |-> ##1 lit11 == $past(instr_word[10:0]) &&
      lit9 == $past(instr_word[8:0]) && lit7 == $past(instr_word[6:0]) &&
      lit6 == $past(instr_word[5:0]) && lit5 == $past(instr_word[4:0]);
  endproperty
  a_lit_wide: assert property (p_lit_wide) else $error("wide literal misplaced");

endmodule

`default_nettype wire

// file: test/iwd_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none

module iwd_fetch_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_ready,
  output logic [13:0] instr_word,
  output logic instr_valid,
  output logic skip_taken,
  output logic [1:0] ptr_in_prog
);
  // queued fetches: idle gap after take, skip outcome, pointer targets, word
  logic [19:0] prog [$];
  logic [19:0] ent;
  logic sk_nxt;
  logic taken;
  int wait_n;

  // a take is the rising edge that sees valid and ready together
  always @(posedge clk) begin
    taken <= !rst && instr_valid && instr_ready;
  end

  task automatic push(input logic [13:0] w, input logic [1:0] p, input logic s,
                      input logic [2:0] g);
    prog.push_back({g, s, p, w});
  endtask

  initial begin
    instr_word = 14'h3FFF;
    instr_valid = 1'b0;
    skip_taken = 1'b0;
    ptr_in_prog = 2'h0;
    sk_nxt = 1'b0;
    wait_n = 0;
  end

  // drive off the falling edge; a word is held until the decoder takes it
  always @(negedge clk) begin
    if (rst) begin
      instr_valid <= 1'b0;
      wait_n = 0;
    end else if (taken) begin
      instr_valid <= 1'b0;
      instr_word <= ~instr_word; // a released bus must not look like the old word
      ptr_in_prog <= ~ptr_in_prog;
      skip_taken <= sk_nxt; // datapath verdict stays level for the whole instruction
      wait_n = ent[19:17];
    end else if (!instr_valid && wait_n > 0) begin
      wait_n--;
    end else if (!instr_valid && prog.size() > 0) begin
      ent = prog.pop_front();
      {sk_nxt, ptr_in_prog, instr_word} <= ent[16:0];
      instr_valid <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// file: test/instruction_word_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module instruction_word_decoder_tb_top
  import iwd_pkg::*;
;
  logic clk, rst, instr_valid, instr_ready, skip_taken, busy, nop_cycle, dest_file;
  logic ptr_sel, file_rd, file_wr, acc_wr, open;
  logic [13:0] instr_word, cw, w;
  logic [1:0] ptr_in_prog, phase, pointer_update_mode, cycles;
  iwd_cls_e instr_class;
  iwd_op_e instr_op;
  logic [4:0] eo;
  logic [6:0] file_addr, lit7;
  logic [2:0] bit_num;
  logic [7:0] lit8;
  logic [10:0] lit11;
  logic [4:0] lit5;
  logic [8:0] lit9;
  logic [5:0] lit6;
  logic [8:0] ex;
  logic [58:0] ef, gf;
  int num_errors, samples_checked, n, tot, nrd, nwf, nwa, cyc_cnt;
  logic [13:0] tbl [23] = '{14'h2123, 14'h2A55, 14'h0008, 14'h0009, 14'h000A, 14'h000B,
    14'h3477, 14'h3301, 14'h0025, 14'h3185, 14'h0015, 14'h0012, 14'h3F45, 14'h3100,
    14'h0000, 14'h0080, 14'h0103, 14'h0B81, 14'h0F00, 14'h1F81, 14'h1800, 14'h1401, 14'h377F};

  assign gf = {lit11, lit9, lit8, lit7, lit6, lit5, file_addr, bit_num, pointer_update_mode,
    ptr_sel};

  iwd_decoder dut_u (.clk, .rst, .instr_word, .instr_valid, .instr_ready, .skip_taken,
    .ptr_in_prog, .phase, .busy, .nop_cycle, .instr_class, .instr_op, .file_addr,
    .dest_file, .bit_num, .lit8, .lit11, .lit5, .lit7, .lit9, .lit6, .ptr_sel,
    .pointer_update_mode, .cycles, .file_rd, .file_wr, .acc_wr);

  iwd_fetch_model fm_u (.clk, .rst, .instr_ready, .instr_word, .instr_valid, .skip_taken,
    .ptr_in_prog);

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // reference: {no strobe check, class, planned cycles, skip op, read, file wr, acc wr}
  function automatic logic [8:0] ref_of(input logic [13:0] w, input logic [1:0] p);
    logic nc, sk, rd, wf, wa, two, pen;
    logic [1:0] cls;
    nc = (w[13:4] == 10'h001) || (w[13:8] == 6'h3F);
    two = (w[13:12] == 2'h2) || (w[13:9] == 5'h19) || (w[13:8] == 6'h34) ||
      (w[13:4] == 10'h000 && w[3:2] == 2'h2);
    cls = 2'h2;
    sk = 1'b0;
    rd = 1'b0;
    wf = 1'b0;
    wa = 1'b0;
    if (w[13:12] == 2'h1) begin
      cls = 2'h1;
      rd = 1'b1;
      wf = !w[11];
      sk = w[11];
    end else if ((w[13:12] == 2'h0 && w[11:7] != 5'h0) ||
      (w[13:12] == 2'h3 && w[11:8] inside {4'h5, 4'h6, 4'h7, 4'hB, 4'hD})) begin
      cls = 2'h0;
      rd = 1'b1;
      wf = w[7];
      wa = !w[7];
      sk = w[13:12] == 2'h0 && w[11:8] inside {4'hB, 4'hF};
    end
    // pointer aimed at program memory costs a cycle through either access port
    pen = (rd && w[6:1] == 6'h0 && p[w[0]]) || (w[13:4] == 10'h001 && p[w[2]]) ||
      (w[13:8] == 6'h3F && p[w[6]]);
    return {nc, cls, 2'(1 + two + pen), sk, rd, wf, wa};
  endfunction

  // expected operation, from the word alone
  function automatic logic [4:0] op_of(input logic [13:0] w);
    casez (w)
      14'b00_0000_0000_1000: op_of = OP_RET;
      14'b00_0000_0000_1001: op_of = OP_INT_EXIT;
      14'b00_0000_0000_1010: op_of = OP_ACC_CALL;
      14'b00_0000_0000_1011: op_of = OP_ACC_REL;
      14'b00_0000_0001_????: op_of = OP_PTR_UPD;
      14'b00_0000_001?_????: op_of = OP_BANK;
      14'b00_1011_????_????: op_of = OP_DEC_SKIP;
      14'b00_1111_????_????: op_of = OP_INC_SKIP;
      14'b01_11??_????_????: op_of = OP_SKIP_ONE;
      14'b01_10??_????_????: op_of = OP_SKIP_ZERO;
      14'b10_0???_????_????: op_of = OP_CALL;
      14'b10_1???_????_????: op_of = OP_JUMP;
      14'b11_0100_????_????: op_of = OP_RET_LIT;
      14'b11_001?_????_????: op_of = OP_REL;
      14'b11_0001_1???_????: op_of = OP_PAGE;
      14'b11_0001_0???_????: op_of = OP_PTR_OFS;
      14'b11_1111_????_????: op_of = OP_PTR_IDX;
      default: op_of = OP_PLAIN;
    endcase
  endfunction

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      num_errors++;
      end_of_test();
    end
  end

  // score each word from the falling edge after its take; the skip verdict lands one clock later
  always @(negedge clk) begin
    if (rst) begin
      open = 1'b0;
    end else begin
      n++;
      nrd += file_rd;
      nwf += file_wr;
      nwa += acc_wr;
      if (open && n == 2) begin
        tot = ex[5:4] + (ex[3] & skip_taken);
        chk("busy", 1, busy);
        chk("op", eo, instr_op);
        chk("class", ex[7:6], instr_class);
        chk("cycles", ex[5:4], cycles);
        chk("dest", ex[7:6] == 2'h0 ? cw[7] : ex[7:6] == 2'h1, dest_file);
        chk("fields", ef, gf);
      end
      if (open && n == 5 && tot > 1) chk("nop_cycle", 1, nop_cycle);
      if (open && instr_ready) begin
        open = 1'b0;
        chk("span", 4 * tot, n);
        chk("phase", 3, phase);
        chk("held", ef, gf);
        if (!ex[8]) begin
          chk("file_rd", ex[2], nrd);
          chk("file_wr", ex[1], nwf);
          chk("acc_wr", ex[0], nwa);
        end
      end
      if (fm_u.taken) begin
        cw = instr_word;
        ex = ref_of(instr_word, ptr_in_prog);
        eo = op_of(instr_word);
        ef = {cw[10:0], cw[8:0], cw[7:0], cw[6:0], cw[5:0], cw[4:0], cw[6:0], cw[9:7],
          cw[1:0], cw[13:4] == 10'h001 ? cw[2] : cw[6]};
        open = 1'b1;
        n = 1;
        nrd = 0;
        nwf = 0;
        nwa = 0;
      end
    end
  end

  // corner words with and without penalty and skip, then random words and stalls
  initial begin
    rst = 1'b1;
    void'($urandom(32'h6539));
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst <= 1'b0;
    foreach (tbl[k]) begin
      for (int i = 0; i < 2; i++) fm_u.push(tbl[k], {2{i[0]}}, i[0], 3'(k % 3));
    end
    repeat (300) begin
      w = 14'($urandom);
      if ($urandom % 4 == 0) w[6:1] = 6'h0;
      fm_u.push(w, 2'($urandom), 1'($urandom), 3'($urandom % 7));
    end
    while (fm_u.prog.size() > 0 || instr_valid) @(negedge clk);
    repeat (16) @(negedge clk);
    // reset lands in the middle of a two-cycle jump
    fm_u.push(14'h2ABC, 2'h0, 1'b0, 3'h0);
    repeat (6) @(negedge clk);
    rst <= 1'b1;
    repeat (2) @(negedge clk);
    chk("rst_busy", 0, busy);
    chk("rst_phase", 0, phase);
    chk("rst_fields", 0, gf);
    rst <= 1'b0;
    fm_u.push(14'h0B81, 2'h2, 1'b1, 3'h0);
    repeat (24) @(negedge clk);
    end_of_test();
  end
endmodule

`default_nettype wire
